// *** rsv_core.sv ***
// Clock supervisor register core: byte-wide register port, calendar, alarm, watchdog
//
// Notes on behaviour
// - Two RAM enable outputs drive up to four static RAMs, two per output.
// - Host reaches registers and external RAM with plain byte-wide SRAM cycles.
// - Sixteen byte registers hold time, century, control, alarm, watchdog and flags.
// - RAM enable outputs are held by the block during supply transients.
// - Date rolls over for short months; leap days handled through 2099.
// - Time bytes 9h-Fh and 1h are storage separate from the counters.
// - Counters copy current time into the time bytes once per second.
// - Byte 8h controls host access to time bytes and stores calibration.
// - Byte 7h holds the host-programmed watchdog setting.
// - Watchdog expiry raises reset or interrupt, chosen by the steer bit.
// - Bytes 6h down to 2h hold the alarm settings.
// - Alarm fires when month, date, hour, minute and second all match.
// - Byte 1h holds the century count.
// - Byte 0h reports watchdog, alarm and battery flags.
// - Out-of-tolerance supply blocks register writes and external RAM writes.
// - Below switchover the battery keeps time and data until supply returns.
// - Write strobe high with chip enable and output enable low gives a read at A3-A0.
// - Write spans later falling to earlier rising edge of strobe or enable.
// - Low external RAM select picks external SRAM; host never asserts both.
`timescale 1ns/100ps
module rsv_core
  import rsv_pkg::*;
#(
  parameter int WD_UNIT0_CYCLES   = WD_RES0_US * CLOCK_MHZ,
  parameter int WD_UNIT1_CYCLES   = WD_RES1_US * CLOCK_MHZ,
  parameter int WD_UNIT2_CYCLES   = WD_RES2_US * CLOCK_MHZ,
  parameter int WD_UNIT3_CYCLES   = WD_RES3_US * CLOCK_MHZ,
  parameter int RESET_PULSE_CYCLES = RESET_PULSE_US * CLOCK_MHZ
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] dqIn,
  output logic      [7:0] dqOut,
  output logic            dqOe,
  input  wire logic       chipEnN,
  input  wire logic       outEnN,
  input  wire logic       writeEnN,
  input  wire logic       external_ram_select_n,
  input  wire logic       bankSel,
  input  wire logic       supplyFail,
  input  wire logic       batteryOn,
  input  wire logic       batteryLow,
  input  wire logic       secondTick,
  input  wire logic       watchdogKick,
  output logic            ramEnableOutOne,
  output logic            ramEnableOutTwo,
  output logic            resetOutOe,
  output logic            irqOutOe
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    rsv_pins_t         s1;
    rsv_pins_t         s2;
    logic [15:0][7:0]  regs;
    rsv_time_t         cnt;
    logic              wrPrev;
    logic              wrBlock;
    logic [7:0]        wrData;
    logic              rdPrev;
    logic              tickPrev;
    logic              kickPrev;
    logic [31:0]       wdUnit;
    logic [4:0]        wdMult;
    logic [31:0]       rstCnt;
    rsv_out_t          out;
  } rsv_state_t;

  rsv_state_t s;
  rsv_state_t next_s;
  rsv_pins_t  pinsIn;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // BCD increment with wrap from last to first
  function automatic logic [7:0] bcdNext(input logic [7:0] v, input logic [7:0] last,
                                         input logic [7:0] first);
    if (v == last) begin
      return first;
    end else if (v[3:0] == BCD_NINE) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
  endfunction : bcdNext

  // Leap year from a two-digit BCD year: divisible by four
  function automatic logic isLeap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : isLeap

  // Last date of a month in BCD
  function automatic logic [7:0] lastDate(input logic [7:0] m, input logic [7:0] y);
    if (m == BCD_FEB) begin
      return isLeap(y) ? BCD_D29 : BCD_D28;
    end else if (m == BCD_APR || m == BCD_JUN || m == BCD_SEP || m == BCD_NOV) begin
      return BCD_D30;
    end
    return BCD_D31;
  endfunction : lastDate

  // Watchdog resolution step in clock cycles
  function automatic logic [31:0] wdUnitCycles(input logic [1:0] res);
    unique case (res)
      2'h0: return WD_UNIT0_CYCLES[31:0];
      2'h1: return WD_UNIT1_CYCLES[31:0];
      2'h2: return WD_UNIT2_CYCLES[31:0];
      2'h3: return WD_UNIT3_CYCLES[31:0];
    endcase
  endfunction : wdUnitCycles

  // ----------------------------------------------------------------------------
  // Pin gathering
  // ----------------------------------------------------------------------------
  always_comb begin
    pinsIn.addr         = addr;
    pinsIn.data         = dqIn;
    pinsIn.ceN          = chipEnN;
    pinsIn.oeN          = outEnN;
    pinsIn.weN          = writeEnN;
    pinsIn.extRamSelN   = external_ram_select_n;
    pinsIn.bankSel      = bankSel;
    pinsIn.supplyFail   = supplyFail;
    pinsIn.batteryOn    = batteryOn;
    pinsIn.batteryLow   = batteryLow;
    pinsIn.secondTick   = secondTick;
    pinsIn.watchdogKick = watchdogKick;
  end

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    rsv_pins_t  p;
    logic       protect;
    logic       wrAct;
    logic       rdAct;
    logic       tickEv;
    logic       kickEv;
    logic       wdLoad;
    logic       wdExpire;
    logic [7:0] wdReg;
    rsv_time_t  t;
    p        = s.s2;
    protect  = 1'b0;
    wrAct    = 1'b0;
    rdAct    = 1'b0;
    tickEv   = 1'b0;
    kickEv   = 1'b0;
    wdLoad   = 1'b0;
    wdExpire = 1'b0;
    wdReg    = REG_RESET;
    t        = s.cnt;
    next_s   = s;

    // Two-flop synchronisers on every pin
    next_s.s1 = pinsIn;
    next_s.s2 = s.s1;

    protect = p.supplyFail | p.batteryOn;
    tickEv  = p.secondTick & ~s.tickPrev;
    kickEv  = p.watchdogKick & ~s.kickPrev;
    next_s.tickPrev = p.secondTick;
    next_s.kickPrev = p.watchdogKick;

    // Write window: both strobes low, ends on first one to rise
    wrAct = ~p.ceN & ~p.weN;
    next_s.wrPrev  = wrAct;
    next_s.wrBlock = wrAct ? (s.wrBlock | protect) : 1'b0;
    if (wrAct) begin
      next_s.wrData = p.data;
    end
    if (~wrAct && s.wrPrev && ~s.wrBlock && ~protect) begin
      unique case (p.addr)
        STATUS_FLAGS_OFS: ; // Flags are read-only
        CLOCK_CONTROL_OFS: begin
          // Clearing the write bit loads the host-set time into the counters
          if (s.regs[CLOCK_CONTROL_OFS][CTL_WRITE_BIT] && ~s.wrData[CTL_WRITE_BIT]) begin
            t.sec     = s.regs[SEC_OFS];
            t.min     = s.regs[MIN_OFS];
            t.hour    = s.regs[HOUR_OFS];
            t.day     = s.regs[DAY_OFS];
            t.date    = s.regs[DATE_OFS];
            t.month   = s.regs[MONTH_OFS];
            t.year    = s.regs[YEAR_OFS];
            t.century = s.regs[CENTURY_OFS];
          end
          next_s.regs[CLOCK_CONTROL_OFS] = s.wrData;
        end
        WATCHDOG_OFS: begin
          next_s.regs[WATCHDOG_OFS] = s.wrData;
          wdLoad = 1'b1;
        end
        default: next_s.regs[p.addr] = s.wrData;
      endcase
    end

    // Calendar advance on each second update
    if (tickEv) begin
      t.sec = bcdNext(t.sec, BCD_SEC_LAST, BCD_ZERO);
      if (t.sec == BCD_ZERO) begin
        t.min = bcdNext(t.min, BCD_SEC_LAST, BCD_ZERO);
        if (t.min == BCD_ZERO) begin
          t.hour = bcdNext(t.hour, BCD_HOUR_LAST, BCD_ZERO);
          if (t.hour == BCD_ZERO) begin
            t.day  = bcdNext(t.day, BCD_DAY_LAST, BCD_ONE);
            t.date = bcdNext(t.date, lastDate(t.month, t.year), BCD_ONE);
            if (t.date == BCD_ONE) begin
              t.month = bcdNext(t.month, BCD_MONTH_LAST, BCD_ONE);
              if (t.month == BCD_ONE) begin
                t.year = bcdNext(t.year, BCD_YEAR_LAST, BCD_ZERO);
                if (t.year == BCD_ZERO) begin
                  t.century = bcdNext(t.century, BCD_YEAR_LAST, BCD_ZERO);
                end
              end
            end
          end
        end
      end
      // Copy into the time bytes unless the host holds them
      if (~next_s.regs[CLOCK_CONTROL_OFS][CTL_WRITE_BIT] &&
          ~next_s.regs[CLOCK_CONTROL_OFS][CTL_READ_BIT]) begin
        next_s.regs[SEC_OFS]     = t.sec;
        next_s.regs[MIN_OFS]     = t.min;
        next_s.regs[HOUR_OFS]    = t.hour;
        next_s.regs[DAY_OFS]     = t.day;
        next_s.regs[DATE_OFS]    = t.date;
        next_s.regs[MONTH_OFS]   = t.month;
        next_s.regs[YEAR_OFS]    = t.year;
        next_s.regs[CENTURY_OFS] = t.century;
      end
    end
    next_s.cnt = t;

    // Flag read completes: clear sticky flags before any new set
    rdAct = ~p.ceN & p.weN & ~p.oeN & (p.addr == STATUS_FLAGS_OFS);
    next_s.rdPrev = rdAct;
    if (s.rdPrev && ~rdAct) begin
      next_s.regs[STATUS_FLAGS_OFS][FLAG_ALARM_BIT] = 1'b0;
      next_s.regs[STATUS_FLAGS_OFS][FLAG_WDOG_BIT]  = 1'b0;
    end

    // Alarm match on the new time
    if (tickEv &&
        (t.month == (s.regs[ALM_MONTH_OFS] & ALARM_FIELD_MSK)) &&
        (t.date  == (s.regs[ALM_DATE_OFS]  & ALARM_FIELD_MSK)) &&
        (t.hour  == (s.regs[ALM_HOUR_OFS]  & ALARM_FIELD_MSK)) &&
        (t.min   == (s.regs[ALM_MIN_OFS]   & ALARM_FIELD_MSK)) &&
        (t.sec   == (s.regs[ALM_SEC_OFS]   & ALARM_FIELD_MSK))) begin
      next_s.regs[STATUS_FLAGS_OFS][FLAG_ALARM_BIT] = 1'b1;
    end

    // Watchdog: multiplier steps of the chosen resolution; zero multiplier stops it
    wdReg = next_s.regs[WATCHDOG_OFS];
    if (wdLoad || kickEv) begin
      next_s.wdMult = wdReg[WD_MULT_HI:WD_MULT_LO];
      next_s.wdUnit = wdUnitCycles(wdReg[1:0]);
    end else if (s.wdMult != 5'h00) begin
      if (s.wdUnit > 32'h1) begin
        next_s.wdUnit = s.wdUnit - 32'h1;
      end else begin
        next_s.wdMult = s.wdMult - 5'h01;
        next_s.wdUnit = wdUnitCycles(wdReg[1:0]);
        wdExpire      = (s.wdMult == 5'h01);
      end
    end
    if (wdExpire) begin
      next_s.regs[STATUS_FLAGS_OFS][FLAG_WDOG_BIT] = 1'b1;
      if (wdReg[WD_STEER_BIT]) begin
        next_s.rstCnt = RESET_PULSE_CYCLES[31:0];
      end
    end else if (s.rstCnt != 32'h0) begin
      next_s.rstCnt = s.rstCnt - 32'h1;
    end
    next_s.regs[STATUS_FLAGS_OFS][FLAG_BATLOW_BIT] = p.batteryLow;

    // Read data path
    next_s.out.dqOut = next_s.regs[p.addr];
    next_s.out.dqOe  = ~p.ceN & p.weN & ~p.oeN & ~protect;

    // External RAM enables: bank select picks one pair, protection forces both off
    if (protect) begin
      next_s.out.ramEnableOutOne = 1'b1;
      next_s.out.ramEnableOutTwo = 1'b1;
    end else begin
      next_s.out.ramEnableOutOne = p.extRamSelN | p.bankSel;
      next_s.out.ramEnableOutTwo = p.extRamSelN | ~p.bankSel;
    end

    // Open-drain outputs
    next_s.out.resetOe = wdExpire ? wdReg[WD_STEER_BIT] : (s.rstCnt > 32'h1);
    next_s.out.irqOe   = next_s.regs[STATUS_FLAGS_OFS][FLAG_ALARM_BIT] |
                         (next_s.regs[STATUS_FLAGS_OFS][FLAG_WDOG_BIT] &
                          ~wdReg[WD_STEER_BIT]);
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s                         <= '0;
      s.s1.ceN                  <= 1'b1;
      s.s1.weN                  <= 1'b1;
      s.s1.oeN                  <= 1'b1;
      s.s1.extRamSelN           <= 1'b1;
      s.s2.ceN                  <= 1'b1;
      s.s2.weN                  <= 1'b1;
      s.s2.oeN                  <= 1'b1;
      s.s2.extRamSelN           <= 1'b1;
      s.cnt.day                 <= BCD_ONE;
      s.cnt.date                <= BCD_ONE;
      s.cnt.month               <= BCD_ONE;
      s.out.ramEnableOutOne     <= 1'b1;
      s.out.ramEnableOutTwo     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign dqOut           = s.out.dqOut;
  assign dqOe            = s.out.dqOe;
  assign ramEnableOutOne = s.out.ramEnableOutOne;
  assign ramEnableOutTwo = s.out.ramEnableOutTwo;
  assign resetOutOe      = s.out.resetOe;
  assign irqOutOe        = s.out.irqOe;

endmodule : rsv_core

// *** rsv_pkg.sv ***
// Constants, field layouts and state types of the clock supervisor register core
package rsv_pkg;

  // ----------------
  // Register offsets
  // ----------------
  localparam logic [3:0] STATUS_FLAGS_OFS  = 4'h0;
  localparam logic [3:0] CENTURY_OFS       = 4'h1;
  localparam logic [3:0] ALM_SEC_OFS       = 4'h2;
  localparam logic [3:0] ALM_MIN_OFS       = 4'h3;
  localparam logic [3:0] ALM_HOUR_OFS      = 4'h4;
  localparam logic [3:0] ALM_DATE_OFS      = 4'h5;
  localparam logic [3:0] ALM_MONTH_OFS     = 4'h6;
  localparam logic [3:0] WATCHDOG_OFS      = 4'h7;
  localparam logic [3:0] CLOCK_CONTROL_OFS = 4'h8;
  localparam logic [3:0] SEC_OFS           = 4'h9;
  localparam logic [3:0] MIN_OFS           = 4'ha;
  localparam logic [3:0] HOUR_OFS          = 4'hb;
  localparam logic [3:0] DAY_OFS           = 4'hc;
  localparam logic [3:0] DATE_OFS          = 4'hd;
  localparam logic [3:0] MONTH_OFS         = 4'he;
  localparam logic [3:0] YEAR_OFS          = 4'hf;

  // ----------------
  // Field positions and values
  // ----------------
  localparam int         FLAG_WDOG_BIT   = 7;
  localparam int         FLAG_ALARM_BIT  = 6;
  localparam int         FLAG_BATLOW_BIT = 4;
  localparam int         CTL_WRITE_BIT   = 7;
  localparam int         CTL_READ_BIT    = 6;
  localparam int         WD_STEER_BIT    = 7;
  localparam int         WD_MULT_HI      = 6;
  localparam int         WD_MULT_LO      = 2;
  localparam logic [7:0] ALARM_FIELD_MSK = 8'h7f;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] BCD_ZERO        = 8'h00;
  localparam logic [7:0] BCD_ONE         = 8'h01;
  localparam logic [7:0] BCD_SEC_LAST    = 8'h59;
  localparam logic [7:0] BCD_HOUR_LAST   = 8'h23;
  localparam logic [7:0] BCD_DAY_LAST    = 8'h07;
  localparam logic [7:0] BCD_MONTH_LAST  = 8'h12;
  localparam logic [7:0] BCD_YEAR_LAST   = 8'h99;
  localparam logic [7:0] BCD_FEB         = 8'h02;
  localparam logic [7:0] BCD_APR         = 8'h04;
  localparam logic [7:0] BCD_JUN         = 8'h06;
  localparam logic [7:0] BCD_SEP         = 8'h09;
  localparam logic [7:0] BCD_NOV         = 8'h11;
  localparam logic [7:0] BCD_D28         = 8'h28;
  localparam logic [7:0] BCD_D29         = 8'h29;
  localparam logic [7:0] BCD_D30         = 8'h30;
  localparam logic [7:0] BCD_D31         = 8'h31;
  localparam logic [3:0] BCD_NINE        = 4'h9;

  // ----------------
  // Timing
  // ----------------
  localparam int CLOCK_MHZ       = 250;
  localparam int WD_RES0_US      = 62500;
  localparam int WD_RES1_US      = 250000;
  localparam int WD_RES2_US      = 1000000;
  localparam int WD_RES3_US      = 4000000;
  localparam int RESET_PULSE_US  = 40000;

  // ----------------
  // Carriers
  // ----------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
    logic       ceN;
    logic       oeN;
    logic       weN;
    logic       extRamSelN;
    logic       bankSel;
    logic       supplyFail;
    logic       batteryOn;
    logic       batteryLow;
    logic       secondTick;
    logic       watchdogKick;
  } rsv_pins_t;

  typedef struct packed {
    logic [7:0] dqOut;
    logic       dqOe;
    logic       ramEnableOutOne;
    logic       ramEnableOutTwo;
    logic       resetOe;
    logic       irqOe;
  } rsv_out_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] century;
  } rsv_time_t;

endpackage : rsv_pkg

// *** rsv_core_sva.sv ***
// Port checker of the clock supervisor register core
`timescale 1ns/100ps
module rsv_core_sva
  import rsv_pkg::*;
#(
  parameter int RESET_PULSE_CYCLES = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dqOe,
  input wire logic chipEnN,
  input wire logic outEnN,
  input wire logic writeEnN,
  input wire logic external_ram_select_n,
  input wire logic bankSel,
  input wire logic supplyFail,
  input wire logic batteryOn,
  input wire logic ramEnableOutOne,
  input wire logic ramEnableOutTwo,
  input wire logic resetOutOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------
  // Length of the running reset pulse
  // ----------------
  logic [31:0] pulseLen;
  always_ff @(posedge clock) begin
    if (!rst_n || !resetOutOe)
      pulseLen <= '0;
    else
      pulseLen <= pulseLen + 32'h1;
  end

  // ----------------
  // Input conditions held long enough to pass the synchronisers
  // ----------------
  sequence s_protected;
    (supplyFail || batteryOn) [*5];
  endsequence
  sequence s_selOne;
    (!supplyFail && !batteryOn && !external_ram_select_n && !bankSel) [*5];
  endsequence
  sequence s_selTwo;
    (!supplyFail && !batteryOn && !external_ram_select_n && bankSel) [*5];
  endsequence
  sequence s_readHeld;
    (!chipEnN && !outEnN && writeEnN && !supplyFail && !batteryOn) [*5];
  endsequence

  a_protect_enables_high: assert property (s_protected |-> ramEnableOutOne && ramEnableOutTwo)
    else $error("RAM enables not forced high under protection");
  a_protect_no_drive: assert property (s_protected |-> !dqOe)
    else $error("Data bus driven under protection");
  a_bank_one_select: assert property (s_selOne |-> !ramEnableOutOne && ramEnableOutTwo)
    else $error("Bank low did not select RAM enable one alone");
  a_bank_two_select: assert property (s_selTwo |-> ramEnableOutOne && !ramEnableOutTwo)
    else $error("Bank high did not select RAM enable two alone");
  a_ext_deselect: assert property (external_ram_select_n [*5] |-> ramEnableOutOne && ramEnableOutTwo)
    else $error("RAM enable active while external select is high");
  a_read_drives_bus: assert property (s_readHeld |-> dqOe)
    else $error("Read cycle did not drive the data bus");
  a_idle_no_drive: assert property (chipEnN [*5] |-> !dqOe)
    else $error("Data bus driven while deselected");
  a_reset_pulse_len: assert property ($fell(resetOutOe) |-> pulseLen >= RESET_PULSE_CYCLES && pulseLen <= RESET_PULSE_CYCLES + 1)
    else $error("Reset pulse length wrong");
endmodule : rsv_core_sva

// *** rsv_host_model.sv ***
// Host bus model issuing byte-wide asynchronous SRAM cycles
`timescale 1ns/100ps
module rsv_host_model
  import rsv_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] dqOut,
  input  wire logic       dqOe,
  output logic      [3:0] addr,
  output logic      [7:0] dqIn,
  output logic            chipEnN,
  output logic            outEnN,
  output logic            writeEnN,
  output logic            external_ram_select_n,
  output logic            bankSel
);
  localparam int PHASE = 4;  // Strobe phase in clocks, longer than the sync depth

  // Idle bus at time zero
  initial begin
    addr = 4'h0;
    dqIn = 8'h00;
    chipEnN = 1'b1;
    outEnN = 1'b1;
    writeEnN = 1'b1;
    external_ram_select_n = 1'b1;
    bankSel = 1'b0;
  end

  // Write: address and data held through the strobe and after it
  task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    addr = a;
    dqIn = d;
    chipEnN = 1'b0;
    writeEnN = 1'b0;
    repeat (PHASE) @(posedge clock);
    #1 writeEnN = 1'b1;
    repeat (PHASE) @(posedge clock);
    #1 chipEnN = 1'b1;
    dqIn = ~d;  // Released bus shows no stale value
    repeat (PHASE) @(posedge clock);
  endtask : write_byte

  // Read: strobe high, enables low, sampled at a clock edge before release
  task automatic read_byte(input logic [3:0] a, output logic [7:0] d, output logic oe);
    @(posedge clock) #1;
    addr = a;
    chipEnN = 1'b0;
    outEnN = 1'b0;
    repeat (PHASE + 1) @(posedge clock);
    #1 d = dqOut;
    oe = dqOe;
    chipEnN = 1'b1;
    outEnN = 1'b1;
    repeat (PHASE) @(posedge clock);
  endtask : read_byte

  // External RAM select, only while the register enable is idle
  task automatic ram_select(input logic selN, input logic bank);
    @(posedge clock) #1;
    external_ram_select_n = selN | ~chipEnN;
    bankSel = bank;
  endtask : ram_select
endmodule : rsv_host_model

// *** rsv_core_tb_top.sv ***
// Self-checking testbench of the clock supervisor register core
`timescale 1ns/100ps
module rsv_core_tb_top
  import rsv_pkg::*;
;
  logic [3:0] addr;
  logic [7:0] dqIn, dqOut;
  logic       clock, rst_n, dqOe, chipEnN, outEnN, writeEnN, external_ram_select_n, bankSel;
  logic       supplyFail, batteryOn, batteryLow, secondTick, watchdogKick;
  logic       ramEnableOutOne, ramEnableOutTwo, resetOutOe, irqOutOe;
  int         errCount, samplesChecked, cycleCount;
  logic [47:0] calTab [4] = '{48'h280223010323, 48'h280224290224, 48'h300405010505,
                             48'h311299010100};

  rsv_core #(.WD_UNIT0_CYCLES(4), .WD_UNIT1_CYCLES(8), .WD_UNIT2_CYCLES(16),
             .WD_UNIT3_CYCLES(32), .RESET_PULSE_CYCLES(5)) rsv_core_i (
    .clock, .rst_n, .addr, .dqIn, .dqOut, .dqOe, .chipEnN, .outEnN, .writeEnN,
    .external_ram_select_n, .bankSel, .supplyFail, .batteryOn, .batteryLow, .secondTick,
    .watchdogKick, .ramEnableOutOne, .ramEnableOutTwo, .resetOutOe, .irqOutOe);
  rsv_host_model rsv_host_model_i (.clock, .dqOut, .dqOe, .addr, .dqIn, .chipEnN, .outEnN,
    .writeEnN, .external_ram_select_n, .bankSel);

  always #2 clock = ~clock;

  // ----------------
  // Compare, drive and report helpers
  // ----------------
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte
  task automatic check_bit(input string what, input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    rsv_host_model_i.write_byte(a, d);
  endtask : wr
  task automatic read_check(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] got;
    logic       oe;
    rsv_host_model_i.read_byte(a, got, oe);
    check_bit({what, " drive"}, 1'b1, oe);
    check_byte(what, exp, got);
  endtask : read_check
  task automatic tick();
    settle(1);
    secondTick = 1'b1;
    settle(4);
    secondTick = 1'b0;
    settle(6);
  endtask : tick
  task automatic final_report();
    if (errCount == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset_values();
    check_bit("dqOe", 1'b0, dqOe);
    check_bit("ram one", 1'b1, ramEnableOutOne);
    check_bit("ram two", 1'b1, ramEnableOutTwo);
    check_bit("reset out", 1'b0, resetOutOe);
    check_bit("irq out", 1'b0, irqOutOe);
    read_check(CENTURY_OFS, REG_RESET, "century");
    read_check(WATCHDOG_OFS, REG_RESET, "watchdog");
    read_check(CLOCK_CONTROL_OFS, REG_RESET, "control");
  endtask : t_reset_values

  task automatic t_register_file();
    wr(CENTURY_OFS, 8'h20);
    read_check(CENTURY_OFS, 8'h20, "century");
    for (int i = 2; i < 7; i++) begin
      wr(i[3:0], 8'h30 + i[7:0]);
      read_check(i[3:0], 8'h30 + i[7:0], "alarm byte");
    end
    wr(STATUS_FLAGS_OFS, 8'hff);
    read_check(STATUS_FLAGS_OFS, 8'h00, "flags read only");
  endtask : t_register_file

  task automatic t_ram_select();
    logic [5:0] rows [5] = '{6'b000001, 6'b010010, 6'b100011, 6'b001011, 6'b010111};
    for (int i = 0; i < 5; i++) begin
      rsv_host_model_i.ram_select(rows[i][5], rows[i][4]);
      supplyFail = rows[i][3];
      batteryOn = rows[i][2];
      settle(5);
      check_bit("ram one", rows[i][1], ramEnableOutOne);
      check_bit("ram two", rows[i][0], ramEnableOutTwo);
    end
    rsv_host_model_i.ram_select(1'b1, 1'b0);
    supplyFail = 1'b0;
    batteryOn = 1'b0;
    settle(5);
  endtask : t_ram_select

  task automatic t_protected_write();
    for (int i = 0; i < 2; i++) begin
      supplyFail = (i == 0);
      batteryOn = (i == 1);
      settle(4);
      wr(CENTURY_OFS, 8'h55);
      supplyFail = 1'b0;
      batteryOn = 1'b0;
      settle(6);
      read_check(CENTURY_OFS, 8'h20, "protected century");
    end
  endtask : t_protected_write

  task automatic t_calendar();
    logic [47:0] row;
    for (int i = 0; i < 4; i++) begin
      row = calTab[i];
      wr(CLOCK_CONTROL_OFS, 8'h80);
      wr(SEC_OFS, BCD_SEC_LAST);
      wr(MIN_OFS, BCD_SEC_LAST);
      wr(HOUR_OFS, BCD_HOUR_LAST);
      wr(DAY_OFS, BCD_DAY_LAST);
      wr(DATE_OFS, row[47:40]);
      wr(MONTH_OFS, row[39:32]);
      wr(YEAR_OFS, row[31:24]);
      wr(CLOCK_CONTROL_OFS, 8'h00);
      tick();
      read_check(SEC_OFS, BCD_ZERO, "second");
      read_check(DAY_OFS, BCD_ONE, "day");
      read_check(DATE_OFS, row[23:16], "date");
      read_check(MONTH_OFS, row[15:8], "month");
      read_check(YEAR_OFS, row[7:0], "year");
    end
    wr(CLOCK_CONTROL_OFS, 8'h40);
    tick();
    read_check(SEC_OFS, BCD_ZERO, "frozen second");
    wr(CLOCK_CONTROL_OFS, 8'h00);
  endtask : t_calendar

  task automatic t_watchdog();
    wr(WATCHDOG_OFS, 8'h84);
    for (int i = 0; i < 100 && resetOutOe !== 1'b1; i++) settle(1);
    check_bit("watchdog reset", 1'b1, resetOutOe);
    read_check(STATUS_FLAGS_OFS, 8'h80, "reset flag");
    wr(WATCHDOG_OFS, 8'h04);
    for (int i = 0; i < 100 && irqOutOe !== 1'b1; i++) settle(1);
    check_bit("watchdog irq", 1'b1, irqOutOe);
    wr(WATCHDOG_OFS, 8'h00);
    read_check(STATUS_FLAGS_OFS, 8'h80, "watchdog flag");
    settle(5);
    check_bit("irq released", 1'b0, irqOutOe);
    read_check(STATUS_FLAGS_OFS, 8'h00, "flags cleared");
    wr(WATCHDOG_OFS, 8'h7f);
    for (int i = 0; i < 8; i++) begin
      watchdogKick = 1'b1;
      settle(4);
      watchdogKick = 1'b0;
      settle(150);
    end
    check_bit("kicked irq", 1'b0, irqOutOe);
    wr(WATCHDOG_OFS, 8'h00);
  endtask : t_watchdog

  task automatic t_alarm();
    logic [7:0] alm [5] = '{8'h02, 8'h00, 8'h00, 8'h01, 8'h01};
    for (int i = 0; i < 5; i++) wr(ALM_SEC_OFS + i[3:0], alm[i]);
    batteryOn = 1'b1;
    tick();
    batteryOn = 1'b0;
    check_bit("alarm irq", 1'b1, irqOutOe);
    read_check(STATUS_FLAGS_OFS, 8'h40, "alarm flag");
    read_check(STATUS_FLAGS_OFS, 8'h00, "alarm flag cleared");
    batteryLow = 1'b1;
    settle(5);
    read_check(STATUS_FLAGS_OFS, 8'h10, "battery flag");
    batteryLow = 1'b0;
  endtask : t_alarm

  // ----------------
  // Main sequence and hang guard
  // ----------------
  always @(posedge clock) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      errCount++;
      final_report();
    end
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {supplyFail, batteryOn, batteryLow, secondTick, watchdogKick} = 5'h00;
    settle(4);
    rst_n = 1'b1;
    settle(3);
    t_reset_values();
    t_register_file();
    t_ram_select();
    t_protected_write();
    t_calendar();
    t_watchdog();
    t_alarm();
    final_report();
  end
endmodule : rsv_core_tb_top

bind rsv_core rsv_core_sva #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) rsv_core_sva_i (
  .clock, .rst_n, .dqOe, .chipEnN, .outEnN, .writeEnN, .external_ram_select_n, .bankSel,
  .supplyFail, .batteryOn, .ramEnableOutOne, .ramEnableOutTwo, .resetOutOe);
